// file: tsi_cfg_pkg.sv
// Operation
// - Incoming streams land in a data memory that software reads but never writes
// - Software may read and write every connection memory location
// - Mode 10 sends the word's own low byte on that outgoing slot
// - Address top bits 10 select connection memory, low 14 bits pick location
// - Address bits 13:8 give outgoing stream, bits 7:0 outgoing slot
// - Word bits 13:8 give the source stream number
// - Word bits 7:0 give the source channel number
// - Word bits 15:14: variable, constant, processor, or high-impedance output
// - One write of destination address and source word makes the connection
// - Control at top bits 01: enable bit 9, pattern 8:7, start 6
// - Start rising edge fills whole connection memory within 250 us
// - Fill writes pattern in bits 15:14 and zeros below
// - Fill completion clears the pattern field to 00
// - Regular mode uses one rate; mux/demux lets output rate differ
// - Codes 0100 to 0111 pick the 2M/4M/8M mux/demux combinations
// - Codes 1000 to 1011 pick the 16M mux/demux combinations
package tsi_cfg_pkg;
  localparam int ADDR_W = 16;
  localparam int WORD_W = 16;
  localparam int IDX_W = 14;
  localparam int BYTE_W = 8;
  // Address regions in bits 15:14
  localparam logic [1:0] REGION_DATA = 2'h0;
  localparam logic [1:0] REGION_CTRL = 2'h1;
  localparam logic [1:0] REGION_CONN = 2'h2;
  // Control register fields
  localparam int CTRL_ENABLE_BIT = 9;
  localparam int CTRL_PAT_HI = 8;
  localparam int CTRL_PAT_LO = 7;
  localparam int CTRL_START_BIT = 6;
  localparam int CTRL_RATE_HI = 3;
  localparam int CTRL_BUSY_BIT = 15;
  localparam logic [15:0] CTRL_WR_MASK = 16'h03CF;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // Per-slot switching modes
  localparam logic [1:0] MODE_VARIABLE = 2'h0;
  localparam logic [1:0] MODE_CONSTANT = 2'h1;
  localparam logic [1:0] MODE_PROCESSOR = 2'h2;
  localparam logic [1:0] MODE_HIZ = 2'h3;
  // Stream rate codes
  localparam logic [1:0] RATE_2M = 2'h0;
  localparam logic [1:0] RATE_4M = 2'h1;
  localparam logic [1:0] RATE_8M = 2'h2;
  localparam logic [1:0] RATE_16M = 2'h3;
  localparam logic [1:0] RATE_REGULAR = RATE_2M;
  localparam logic [4:0] STREAMS_ALL = 5'h10;
  // Fill timing
  localparam int FILL_TIME_US = 250;
  localparam int CLK_MHZ = 200;
  localparam int FILL_CYCLES = FILL_TIME_US * CLK_MHZ;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } bus_req_type;

  typedef struct packed {
    logic valid;
    logic [5:0] stream;
    logic [7:0] channel;
    logic [BYTE_W-1:0] data;
  } rx_word_type;

  typedef struct packed {
    logic valid;
    logic [5:0] stream;
    logic [7:0] slot;
  } tx_req_type;

  typedef struct packed {
    logic valid;
    logic oe;
    logic [1:0] mode;
    logic [BYTE_W-1:0] data;
  } tx_word_type;

  typedef struct packed {
    logic mux_mode;
    logic [1:0] rx_rate;
    logic [1:0] tx_rate;
    logic [4:0] rx_streams;
    logic [4:0] tx_streams;
  } rate_cfg_type;
endpackage : tsi_cfg_pkg

// file: fill_walker.sv
`timescale 1ns/1ps
// Walks every connection memory index once, one per clock
module fill_walker #(
  parameter int AW = 14
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic go_in,
  output logic busy_out,
  output logic done_out,
  output logic [AW-1:0] addr_out
);
  logic busy_r, busy_nxt;
  logic done_r, done_nxt;
  logic [AW-1:0] addr_r, addr_nxt;

  // Next state; a go while busy is ignored so one walk always completes
  always_comb begin
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    addr_nxt = addr_r;
    if (busy_r) begin
      addr_nxt = addr_r + 1'b1;
      if (&addr_r) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end
    end else if (go_in) begin
      busy_nxt = 1'b1;
      addr_nxt = '0;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      addr_r <= '0;
    end else begin
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      addr_r <= addr_nxt;
    end
  end

  assign busy_out = busy_r;
  assign done_out = done_r;
  assign addr_out = addr_r;
endmodule : fill_walker

// file: slot_switch_ctrl.sv
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps
module slot_switch_ctrl #(
  parameter int FILL_LIMIT = tsi_cfg_pkg::FILL_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire tsi_cfg_pkg::bus_req_type bus_in,
  output logic [tsi_cfg_pkg::WORD_W-1:0] rdata_out,
  input wire tsi_cfg_pkg::rx_word_type rx_in,
  input wire tsi_cfg_pkg::tx_req_type tx_req_in,
  output tsi_cfg_pkg::tx_word_type tx_out,
  output tsi_cfg_pkg::rate_cfg_type rate_cfg_out,
  output logic fill_busy_out
);
  import tsi_cfg_pkg::*;

  localparam int DEPTH = 1 << IDX_W;

  // Storage: source words per destination, and buffered input bytes
  logic [WORD_W-1:0] conn_mem [DEPTH];
  logic [BYTE_W-1:0] data_mem [DEPTH];

  logic [WORD_W-1:0] ctrl_r, ctrl_nxt;
  logic start_prev_r, start_prev_nxt;
  logic [1:0] fill_pat_r, fill_pat_nxt;
  logic [WORD_W-1:0] rdata_r, rdata_nxt;
  tx_word_type tx_r, tx_nxt;
  rate_cfg_type rate_r, rate_nxt;
  logic fill_go;
  logic fill_busy;
  logic fill_done;
  logic [IDX_W-1:0] fill_addr;
  logic [1:0] bus_region;
  logic [IDX_W-1:0] bus_idx;
  logic conn_we;
  logic [IDX_W-1:0] conn_waddr;
  logic [WORD_W-1:0] conn_wdata;
  logic [WORD_W-1:0] slot_word;
  logic [BYTE_W-1:0] slot_src_byte;

  assign bus_region = bus_in.addr[ADDR_W-1:ADDR_W-2];
  assign bus_idx = bus_in.addr[IDX_W-1:0];

  // Fill engine; one location per clock finishes long before the limit
  fill_walker #(
    .AW(IDX_W)
  ) walker (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .go_in(fill_go),
    .busy_out(fill_busy),
    .done_out(fill_done),
    .addr_out(fill_addr)
  );

  // Start is taken on a 0-to-1 change of the start bit with fill enabled
  assign fill_go = ctrl_r[CTRL_START_BIT] && !start_prev_r
    && ctrl_r[CTRL_ENABLE_BIT];

  // Control register next state
  always_comb begin
    ctrl_nxt = ctrl_r;
    start_prev_nxt = ctrl_r[CTRL_START_BIT];
    fill_pat_nxt = fill_pat_r;
    // A start during a walk is ignored, so the latched pattern must not move
    if (fill_go && !fill_busy) begin
      fill_pat_nxt = ctrl_r[CTRL_PAT_HI:CTRL_PAT_LO];
    end
    if (fill_done) begin
      ctrl_nxt[CTRL_PAT_HI:CTRL_PAT_LO] = 2'h0;
    end
    // A software write in the completion cycle lands after the clear
    if (bus_in.wr && bus_region == REGION_CTRL) begin
      ctrl_nxt = bus_in.wdata & CTRL_WR_MASK;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_r <= CTRL_RESET;
      start_prev_r <= 1'b0;
      fill_pat_r <= 2'h0;
    end else begin
      ctrl_r <= ctrl_nxt;
      start_prev_r <= start_prev_nxt;
      fill_pat_r <= fill_pat_nxt;
    end
  end

  // Connection memory write port; the fill owns it while it runs
  always_comb begin
    conn_we = 1'b0;
    conn_waddr = bus_idx;
    conn_wdata = bus_in.wdata;
    if (fill_busy) begin
      conn_we = 1'b1;
      conn_waddr = fill_addr;
      conn_wdata = {fill_pat_r, {IDX_W{1'b0}}};
    end else if (bus_in.wr && bus_region == REGION_CONN) begin
      conn_we = 1'b1;
    end
  end

  // Memories carry no reset; contents are undefined until written or filled
  always_ff @(posedge ref_clk_in) begin
    if (conn_we) begin
      conn_mem[conn_waddr] <= conn_wdata;
    end
    // Only the receive side writes the data memory
    if (rx_in.valid) begin
      data_mem[{rx_in.stream, rx_in.channel}] <= rx_in.data;
    end
  end

  // Register read path, answer in the next cycle only
  always_comb begin
    rdata_nxt = '0;
    if (bus_in.rd) begin
      case (bus_region)
        REGION_DATA: rdata_nxt = {{(WORD_W-BYTE_W){1'b0}}, data_mem[bus_idx]};
        REGION_CTRL: begin
          rdata_nxt = ctrl_r;
          rdata_nxt[CTRL_BUSY_BIT] = fill_busy;
        end
        REGION_CONN: rdata_nxt = conn_mem[bus_idx];
        default: rdata_nxt = '0;
      endcase
    end
  end

  // Outgoing slot lookup: destination picks the word, word picks the source
  assign slot_word = conn_mem[{tx_req_in.stream, tx_req_in.slot}];
  assign slot_src_byte = data_mem[{slot_word[13:8], slot_word[7:0]}];

  always_comb begin
    tx_nxt = '0;
    tx_nxt.valid = tx_req_in.valid;
    // Mode only with a request, so an idle slot never shows stale memory
    if (tx_req_in.valid) begin
      tx_nxt.mode = slot_word[15:14];
      case (slot_word[15:14])
        MODE_PROCESSOR: begin
          tx_nxt.oe = 1'b1;
          tx_nxt.data = slot_word[BYTE_W-1:0];
        end
        MODE_HIZ: begin
          tx_nxt.oe = 1'b0;
          tx_nxt.data = '0;
        end
        default: begin
          // Variable and constant delay differ only in frame alignment downstream
          tx_nxt.oe = 1'b1;
          tx_nxt.data = slot_src_byte;
        end
      endcase
    end
  end

  // Rate-matching decode of the four select bits
  always_comb begin
    rate_nxt.mux_mode = 1'b1;
    rate_nxt.rx_rate = RATE_REGULAR;
    rate_nxt.tx_rate = RATE_REGULAR;
    rate_nxt.rx_streams = STREAMS_ALL;
    rate_nxt.tx_streams = STREAMS_ALL;
    case (ctrl_r[CTRL_RATE_HI:0])
      4'h4: begin
        rate_nxt.tx_rate = RATE_8M;
        rate_nxt.tx_streams = 5'h04;
      end
      4'h5: begin
        rate_nxt.rx_rate = RATE_8M;
        rate_nxt.rx_streams = 5'h04;
      end
      4'h6: begin
        rate_nxt.rx_rate = RATE_4M;
        rate_nxt.tx_rate = RATE_8M;
        rate_nxt.tx_streams = 5'h08;
      end
      4'h7: begin
        rate_nxt.rx_rate = RATE_8M;
        rate_nxt.tx_rate = RATE_4M;
        rate_nxt.rx_streams = 5'h08;
      end
      4'h8: begin
        rate_nxt.rx_rate = RATE_16M;
        rate_nxt.rx_streams = 5'h02;
      end
      4'h9: begin
        rate_nxt.tx_rate = RATE_16M;
        rate_nxt.tx_streams = 5'h04;
      end
      4'hA: begin
        rate_nxt.rx_rate = RATE_16M;
        rate_nxt.tx_rate = RATE_8M;
        rate_nxt.rx_streams = 5'h08;
      end
      4'hB: begin
        rate_nxt.rx_rate = RATE_8M;
        rate_nxt.tx_rate = RATE_16M;
        rate_nxt.tx_streams = 5'h08;
      end
      default: begin
        rate_nxt.mux_mode = 1'b0;
      end
    endcase
  end

  // Output registers
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_r <= '0;
      tx_r <= '0;
      rate_r <= '0;
      fill_busy_out <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      tx_r <= tx_nxt;
      rate_r <= rate_nxt;
      fill_busy_out <= fill_busy;
    end
  end

  assign rdata_out = rdata_r;
  assign tx_out = tx_r;
  assign rate_cfg_out = rate_r;

  // Helper: cycles spent in one fill, checked against the limit
  logic [31:0] fill_cnt_r;
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      fill_cnt_r <= '0;
    end else if (fill_busy) begin
      fill_cnt_r <= fill_cnt_r + 32'h0000_0001;
    end else begin
      fill_cnt_r <= '0;
    end
  end

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  data_readonly_a: assert property (
    (bus_in.wr && bus_region == REGION_DATA && !rx_in.valid)
      |=> data_mem[$past(bus_idx)] == $past(data_mem[bus_idx]))
    else $error("software write changed the data memory");

  conn_readback_a: assert property (
    (bus_in.wr && bus_region == REGION_CONN && !fill_busy)
      ##1 (bus_in.rd && bus_in.addr == $past(bus_in.addr))
      |=> rdata_out == $past(bus_in.wdata, 2))
    else $error("connection word read back differs from write");

  proc_mode_a: assert property (
    (tx_req_in.valid && slot_word[15:14] == MODE_PROCESSOR)
      |=> (tx_out.oe && tx_out.data == $past(slot_word[7:0])))
    else $error("processor mode slot did not carry its own byte");

  hiz_mode_a: assert property (
    (tx_req_in.valid && slot_word[15:14] == MODE_HIZ) |=> !tx_out.oe)
    else $error("high impedance slot still driven");

  fill_start_a: assert property (
    (bus_in.wr && bus_region == REGION_CTRL && !ctrl_r[CTRL_START_BIT]
      && bus_in.wdata[CTRL_START_BIT] && bus_in.wdata[CTRL_ENABLE_BIT] && !fill_busy)
      |=> ##1 fill_busy ##1 fill_busy_out)
    else $error("fill did not start after start bit rose");

  fill_limit_a: assert property (
    fill_cnt_r < FILL_LIMIT)
    else $error("fill ran past its time limit");

  fill_word_a: assert property (
    fill_busy |-> (conn_we && conn_wdata[IDX_W-1:0] == '0
      && conn_wdata[15:14] == fill_pat_r && conn_waddr == fill_addr))
    else $error("fill wrote a wrong word or address");

  pattern_clear_a: assert property (
    (fill_done && !(bus_in.wr && bus_region == REGION_CTRL))
      |=> ctrl_r[CTRL_PAT_HI:CTRL_PAT_LO] == 2'h0)
    else $error("fill pattern not cleared at completion");

  rate_default_a: assert property (
    (ctrl_r[3:2] == 2'h0 || ctrl_r[3:2] == 2'h3) |=> !rate_cfg_out.mux_mode)
    else $error("unlisted rate code left mux mode on");

  rate_mux_a: assert property (
    (ctrl_r[3:0] == 4'h4) |=> (rate_cfg_out.mux_mode
      && rate_cfg_out.tx_rate == RATE_8M && rate_cfg_out.tx_streams == 5'h04))
    else $error("rate code 0100 decoded wrongly");

  fill_lock_a: assert property (
    (fill_busy && bus_in.wr && bus_region == REGION_CONN)
      |-> conn_wdata == {fill_pat_r, {IDX_W{1'b0}}})
    else $error("software write reached memory during fill");

  tx_idle_a: assert property (
    !tx_req_in.valid |=> tx_out == '0)
    else $error("outgoing word not zero without a request");

  src_byte_a: assert property (
    (tx_req_in.valid && !slot_word[15]) |=> tx_out.data == $past(slot_src_byte))
    else $error("switched slot did not carry its source byte");

  fill_pat_hold_a: assert property (
    fill_busy |=> (!fill_busy || fill_pat_r == $past(fill_pat_r)))
    else $error("fill pattern changed during a walk");
endmodule : slot_switch_ctrl

// file: stream_peer.sv
`timescale 1ns/1ps
// Stream equipment at the far side: feeds received bytes, asks for slots
module stream_peer
  import tsi_cfg_pkg::*;
(
  input wire logic ref_clk_in,
  input wire tsi_cfg_pkg::tx_word_type tx_in,
  output tsi_cfg_pkg::rx_word_type rx_out,
  output tsi_cfg_pkg::tx_req_type req_out
);
  // Quiet at start so the design sees no stray request
  initial begin
    rx_out = '0;
    req_out = '0;
  end

  // One byte per call; fields inverted after, so stale data never looks live
  task automatic send_rx(input logic [5:0] s, input logic [7:0] c, input logic [7:0] d);
    rx_out <= '{valid: 1'b1, stream: s, channel: c, data: d};
    @(posedge ref_clk_in);
    rx_out <= '{valid: 1'b0, stream: ~s, channel: ~c, data: ~d};
  endtask : send_rx

  // Ask for one outgoing slot and take the answer in the following cycle
  task automatic ask_slot(input logic [5:0] s, input logic [7:0] t, output tx_word_type w);
    req_out <= '{valid: 1'b1, stream: s, slot: t};
    @(posedge ref_clk_in);
    req_out <= '{valid: 1'b0, stream: ~s, slot: ~t};
    #1 w = tx_in;
  endtask : ask_slot
endmodule : stream_peer

// file: slot_switch_ctrl_test.sv
`timescale 1ns/1ps
module slot_switch_ctrl_test;
  import tsi_cfg_pkg::*;
  // Tight fill limit just above the walk itself, which is 16384 cycles
  localparam int FILL_LIM = 16500;
  logic ref_clk_in;
  logic sys_rst_in;
  bus_req_type bus_req;
  logic [WORD_W-1:0] rdata;
  rx_word_type rx_w;
  tx_req_type tx_req;
  tx_word_type tx_w;
  tx_word_type got_w;
  rate_cfg_type rate_cfg;
  logic fill_busy;
  int err_total;
  int samples_checked;
  int n;
  logic [15:0] modes [4] = '{16'h4400, 16'h0400, 16'h805A, 16'hC400};
  logic [11:0] tx_exp [4] = '{12'hDA5, 12'hCA5, 12'hE5A, 12'hB00};

  slot_switch_ctrl #(.FILL_LIMIT(FILL_LIM)) u_slot_switch_ctrl (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .bus_in(bus_req),
    .rdata_out(rdata), .rx_in(rx_w), .tx_req_in(tx_req), .tx_out(tx_w),
    .rate_cfg_out(rate_cfg), .fill_busy_out(fill_busy));
  stream_peer u_stream_peer (
    .ref_clk_in(ref_clk_in), .tx_in(tx_w), .rx_out(rx_w), .req_out(tx_req));

  // Expected rate setup for each select code
  function automatic rate_cfg_type rate_exp(input logic [3:0] c);
    case (c)
      4'h4: rate_exp = '{1'b1, RATE_2M, RATE_8M, 5'h10, 5'h04};
      4'h5: rate_exp = '{1'b1, RATE_8M, RATE_2M, 5'h04, 5'h10};
      4'h6: rate_exp = '{1'b1, RATE_4M, RATE_8M, 5'h10, 5'h08};
      4'h7: rate_exp = '{1'b1, RATE_8M, RATE_4M, 5'h08, 5'h10};
      4'h8: rate_exp = '{1'b1, RATE_16M, RATE_2M, 5'h02, 5'h10};
      4'h9: rate_exp = '{1'b1, RATE_2M, RATE_16M, 5'h10, 5'h04};
      4'hA: rate_exp = '{1'b1, RATE_16M, RATE_8M, 5'h08, 5'h10};
      4'hB: rate_exp = '{1'b1, RATE_8M, RATE_16M, 5'h10, 5'h08};
      default: rate_exp = '{1'b0, RATE_2M, RATE_2M, STREAMS_ALL, STREAMS_ALL};
    endcase
  endfunction : rate_exp

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Write holds the bus for one cycle; the next call or idle replaces it
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk_in);
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [15:0] a, input logic [15:0] exp);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge ref_clk_in);
    bus_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hFFFF};
    #1 chk(what, exp, rdata);
    @(posedge ref_clk_in);
  endtask : rd_chk

  task automatic idle(input int k);
    bus_req <= '0;
    repeat (k) @(posedge ref_clk_in);
  endtask : idle

  task automatic final_report();
    if (err_total == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  // Free-running 200 MHz clock
  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end

  // Cuts a hang; generous beside one fill walk
  initial begin
    repeat (60000) @(posedge ref_clk_in);
    err_total++;
    final_report();
  end

  initial begin
    sys_rst_in = 1'b1;
    bus_req = '0;
    err_total = 0;
    samples_checked = 0;
    repeat (5) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge ref_clk_in);
    rd_chk("ctrl reset", 16'h4000, 16'h0000);
    // One write makes the connection, read back on the very next cycle
    wr(16'h8D09, 16'h4400);
    rd_chk("conn word", 16'h8D09, 16'h4400);
    // Received byte readable; software cannot overwrite it
    u_stream_peer.send_rx(6'h04, 8'h00, 8'hA5);
    wr(16'h0400, 16'h005A);
    rd_chk("data mem", 16'h0400, 16'h00A5);
    wr(16'hC000, 16'h1234);
    rd_chk("region 11", 16'hC000, 16'h0000);
    // Every slot mode seen on the outgoing slot
    for (int i = 0; i < 4; i++) begin
      wr(16'h8D09, modes[i]);
      idle(1);
      u_stream_peer.ask_slot(6'h0D, 8'h09, got_w);
      chk("tx word", {4'h0, tx_exp[i]}, {4'h0, got_w});
      @(posedge ref_clk_in);
    end
    // Every rate select code, listed and unlisted
    for (int c = 0; c < 16; c++) begin
      wr(16'h4000, {12'h000, c[3:0]});
      idle(3);
      #1 chk("rate cfg", {1'b0, rate_exp(c[3:0])}, {1'b0, rate_cfg});
      @(posedge ref_clk_in);
    end
    // Fill with pattern 10; a write during the walk must be lost
    wr(16'h4000, 16'h0340);
    idle(3);
    #1 chk("busy up", 16'h0001, {15'h0000, fill_busy});
    @(posedge ref_clk_in);
    wr(16'h8D09, 16'h4400);
    idle(1);
    n = 0;
    while (fill_busy !== 1'b0 && n < 20000) begin
      @(posedge ref_clk_in);
      #1 n++;
    end
    chk("fill in time", 16'h0001, {15'h0000, n < 16400});
    @(posedge ref_clk_in);
    rd_chk("fill word", 16'h8D09, 16'h8000);
    rd_chk("fill last", 16'hBFFF, 16'h8000);
    rd_chk("ctrl after fill", 16'h4000, 16'h0240);
    // Start edge with enable clear leaves memory alone
    wr(16'h4000, 16'h0000);
    wr(16'h4000, 16'h00C0);
    idle(4);
    #1 chk("no fill", 16'h0000, {15'h0000, fill_busy});
    @(posedge ref_clk_in);
    rd_chk("word kept", 16'h8D09, 16'h8000);
    final_report();
  end
endmodule : slot_switch_ctrl_test
